// [common/spmsp_pkg.sv]
package spmsp_pkg;

  // System clock and the fastest serial clock the master may run.
  localparam int CLK_PERIOD_NS      = 5;
  localparam int SCK_MAX_MHZ        = 20;
  localparam int SCK_MIN_PERIOD_NS  = 1000 / SCK_MAX_MHZ;
  // Least serial clock half period in system cycles, rounded up.
  localparam int SCK_MIN_HALF_CYC   =
    (SCK_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Supported opcodes; every other code is treated as invalid.
  localparam logic [7:0] OP_STATUS_WR = 8'h01;
  localparam logic [7:0] OP_MEM_WR    = 8'h02;
  localparam logic [7:0] OP_MEM_RD    = 8'h03;
  localparam logic [7:0] OP_STATUS_RD = 8'h05;

  localparam logic [7:0] STATUS_RST    = 8'h00;
  localparam int         PROTECT_POS   = 7;
  localparam logic [2:0] BIT_CNT_ZERO  = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST  = 3'h7;
  localparam logic [2:0] BIT_CNT_ONE   = 3'h1;
  localparam logic [1:0] ADDR_CNT_ZERO = 2'h0;
  localparam logic [1:0] ADDR_CNT_LAST = 2'h2;
  localparam logic [1:0] ADDR_CNT_ONE  = 2'h1;
  localparam int         SYNC_STAGES   = 2;

  typedef enum logic [4:0] {
    ST_OPCODE  = 5'h01,
    ST_ADDR    = 5'h02,
    ST_WDATA   = 5'h04,
    ST_RDATA   = 5'h08,
    ST_DISCARD = 5'h10
  } spmsp_state_t;

  // One received byte handed to the memory side.
  typedef struct packed {
    logic       is_write;
    logic       is_addr;
    logic [7:0] data;
  } spmsp_rx_t;

  // Pin inputs, carried together through the synchroniser.
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } spmsp_pins_t;

endpackage

// [rtl/spmsp_sync.sv]
`timescale 1ns/1ps
module spmsp_sync
  import spmsp_pkg::*;
#(
  parameter int           W        = 4,
  parameter logic [W-1:0] RST_VAL  = '0
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// [rtl/spmsp_buf.sv]
`timescale 1ns/1ps
module spmsp_buf
  import spmsp_pkg::*;
#(
  parameter int W = 10
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic      [W-1:0] out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  // Head register drives the outputs; the spare entry absorbs one stall.
  logic [W-1:0] spare_reg;
  logic         spare_valid_reg;
  logic         push;
  logic         pop;

  assign push     = in_valid && !spare_valid_reg;
  assign pop      = out_valid && out_ready;
  assign in_ready = !spare_valid_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_valid       <= 1'b0;
      out_data        <= '0;
      spare_valid_reg <= 1'b0;
      spare_reg       <= '0;
    end else if (!out_valid || pop) begin
      if (spare_valid_reg) begin
        out_data        <= spare_reg;
        spare_valid_reg <= 1'b0;
      end else begin
        out_valid <= push;
        out_data  <= in_data;
      end
    end else if (push) begin
      spare_reg       <= in_data;
      spare_valid_reg <= 1'b1;
    end
  end

endmodule

// [rtl/spmsp_slave.sv]
`timescale 1ns/1ps
// Operation
// (R1) Chip select is active low; bus activity counts only while it is low.
// (R2) Chip select high: standby, other inputs ignored, output released.
// (R3) Serial clock edges are gated internally by chip select low.
// (R4) Master makes a chip select falling edge before each opcode.
// (R5) Inputs captured on rising clock edges, outputs change on falling ones.
// (R6) Serial clock from zero to 20 MHz, may pause; device resumes cleanly.
// (R7) Serial input taken only at rising edges, ignored otherwise.
// (R8) Serial output driven only for read data, released otherwise.
// (R9) Protect bit set and write-protect pin low: status writes rejected.
// (R10) Host may join serial input and output; relies on output release.
// (R11) Clock modes 0 and 3 only; rising edge samples in both.
// (R12) First eight bits after chip select falls form the opcode.
// (R13) Every byte travels most significant bit first.
// (R14) Invalid opcode: discard all input until next select, output released.
// (R15) Chip select high clears bit counter and command state.
module spmsp_slave
  import spmsp_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      sys_rst,
  input  wire logic      cs_n_pin,
  input  wire logic      sck_pin,
  input  wire logic      si_pin,
  input  wire logic      wp_n_pin,
  output logic           so_o,
  output logic           so_oe,
  output spmsp_rx_t      rx_data,
  output logic           rx_valid,
  input  wire logic      rx_ready,
  output logic           rd_req,
  input  wire logic [7:0] rd_byte,
  output logic           standby,
  output logic           overrun,
  output logic           status_protect_enable_bit,
  output logic [7:0]     status_o
);

  spmsp_pins_t  pins_raw;
  spmsp_pins_t  pins_s;
  spmsp_state_t state_reg;
  logic         sck_q_reg;
  logic [6:0]   in_sh_reg;
  logic [2:0]   bit_cnt_reg;
  logic [2:0]   out_cnt_reg;
  logic [1:0]   addr_cnt_reg;
  logic         is_write_reg;
  logic         status_cmd_reg;
  logic [7:0]   tx_sh_reg;
  logic [7:0]   status_reg;
  logic         sel;
  logic         rise;
  logic         fall;
  logic         byte_done;
  logic [7:0]   in_byte;
  logic [7:0]   out_byte;
  logic         push;
  logic         buf_ready;
  logic         wr_locked;
  spmsp_rx_t    push_item;

  // Pins read as deselected and unprotected until the synchroniser fills.
  localparam spmsp_pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0,
                                        wp_n: 1'b1};

  assign pins_raw = '{cs_n: cs_n_pin, sck: sck_pin, si: si_pin,
                      wp_n: wp_n_pin};

  // Pins change on the master's schedule, so all of them cross here.
  spmsp_sync #(
    .W       ($bits(spmsp_pins_t)),
    .RST_VAL (PINS_IDLE)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (pins_raw),
    .q       (pins_s)
  );

  // Edges are found by oversampling, so a paused clock simply yields none.
  always_ff @(posedge clk) begin // [R6]
    if (sys_rst) begin
      sck_q_reg <= 1'b0;
    end else begin
      sck_q_reg <= pins_s.sck;
    end
  end

  assign sel       = !pins_s.cs_n; // [R1]
  // Idle level does not matter: both modes sample on the rising edge.
  assign rise      = sel && pins_s.sck && !sck_q_reg; // [R3] [R11]
  assign fall      = sel && !pins_s.sck && sck_q_reg; // [R3] [R5]
  assign byte_done = rise && (bit_cnt_reg == BIT_CNT_LAST);
  assign in_byte   = {in_sh_reg, pins_s.si}; // [R13]
  assign wr_locked = status_reg[PROTECT_POS] && !pins_s.wp_n; // [R9]

  // Serial input is shifted only on a rising edge.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      in_sh_reg <= '0;
    end else if (rise) begin // [R7]
      in_sh_reg <= in_byte[6:0];
    end
  end

  // Deselect acts as a level reset so an aborted command leaves no trace.
  always_ff @(posedge clk) begin
    if (sys_rst || pins_s.cs_n) begin // [R15] [R2]
      state_reg      <= ST_OPCODE;
      bit_cnt_reg    <= BIT_CNT_ZERO;
      addr_cnt_reg   <= ADDR_CNT_ZERO;
      is_write_reg   <= 1'b0;
      status_cmd_reg <= 1'b0;
    end else if (rise) begin
      bit_cnt_reg <= bit_cnt_reg + BIT_CNT_ONE;
      if (byte_done) begin
        unique case (state_reg)
          ST_OPCODE: begin // [R12]
            unique case (in_byte)
              OP_MEM_RD: begin
                state_reg <= ST_ADDR;
              end
              OP_MEM_WR: begin
                state_reg    <= ST_ADDR;
                is_write_reg <= 1'b1;
              end
              OP_STATUS_RD: begin
                state_reg      <= ST_RDATA;
                status_cmd_reg <= 1'b1;
              end
              OP_STATUS_WR: begin
                state_reg      <= ST_WDATA;
                status_cmd_reg <= 1'b1;
                is_write_reg   <= 1'b1;
              end
              default: begin
                state_reg <= ST_DISCARD; // [R14]
              end
            endcase
          end
          ST_ADDR: begin
            addr_cnt_reg <= addr_cnt_reg + ADDR_CNT_ONE;
            if (addr_cnt_reg == ADDR_CNT_LAST) begin
              state_reg <= is_write_reg ? ST_WDATA : ST_RDATA;
            end
          end
          ST_WDATA, ST_RDATA, ST_DISCARD: begin
            state_reg <= state_reg;
          end
        endcase
      end
    end
  end

  // Status register; a locked write completes on the bus but changes nothing.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_reg <= STATUS_RST;
    end else if (byte_done && state_reg == ST_WDATA && status_cmd_reg
                 && !wr_locked) begin // [R9]
      status_reg <= in_byte;
    end
  end

  // Address and write data go to the memory side through the buffer.
  assign push = byte_done && !status_cmd_reg
                && (state_reg == ST_ADDR || state_reg == ST_WDATA);
  assign push_item = '{is_write: is_write_reg,
                       is_addr:  state_reg == ST_ADDR,
                       data:     in_byte};

  spmsp_buf #(
    .W ($bits(spmsp_rx_t))
  ) u_buf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   (push_item),
    .in_valid  (push),
    .in_ready  (buf_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  // The serial link cannot stall, so a full buffer is reported instead.
  always_ff @(posedge clk) begin
    if (sys_rst || pins_s.cs_n) begin
      overrun <= 1'b0;
    end else if (push && !buf_ready) begin
      overrun <= 1'b1;
    end
  end

  // A read byte is requested when the previous byte or address completes.
  always_ff @(posedge clk) begin
    if (sys_rst || pins_s.cs_n) begin
      rd_req <= 1'b0;
    end else begin
      rd_req <= byte_done && !is_write_reg && !status_cmd_reg
                && ((state_reg == ST_ADDR && addr_cnt_reg == ADDR_CNT_LAST)
                    || state_reg == ST_RDATA);
    end
  end

  assign out_byte = (out_cnt_reg != BIT_CNT_ZERO) ? tx_sh_reg
                  : (status_cmd_reg ? status_reg : rd_byte);

  // Output bits move only on falling edges, most significant first.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      so_o      <= 1'b0;
      tx_sh_reg <= '0;
    end else if (fall && state_reg == ST_RDATA) begin // [R5] [R13]
      so_o      <= out_byte[7];
      tx_sh_reg <= {out_byte[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || pins_s.cs_n) begin
      out_cnt_reg <= BIT_CNT_ZERO;
    end else if (fall && state_reg == ST_RDATA) begin
      out_cnt_reg <= out_cnt_reg + BIT_CNT_ONE;
    end
  end

  // Released whenever not returning read data, so SI and SO may be joined.
  always_ff @(posedge clk) begin
    if (sys_rst || pins_s.cs_n) begin // [R2] [R8]
      so_oe <= 1'b0;
    end else if (state_reg != ST_RDATA) begin // [R8] [R10] [R14]
      so_oe <= 1'b0;
    end else if (fall) begin
      so_oe <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      standby                   <= 1'b1;
      status_o                  <= STATUS_RST;
      status_protect_enable_bit <= 1'b0;
    end else begin
      standby                   <= pins_s.cs_n; // [R2]
      status_o                  <= status_reg;
      status_protect_enable_bit <= status_reg[PROTECT_POS];
    end
  end

  a_oe_read_only: assert property ( // [R8]
    @(posedge clk) disable iff (sys_rst)
    so_oe |-> state_reg == ST_RDATA)
    else $error("Output enabled outside read data.");

  a_standby_release: assert property ( // [R2]
    @(posedge clk) disable iff (sys_rst)
    pins_s.cs_n |=> !so_oe && standby)
    else $error("Output not released in standby.");

  a_deselect_clears: assert property ( // [R15]
    @(posedge clk) disable iff (sys_rst)
    pins_s.cs_n |=> state_reg == ST_OPCODE && bit_cnt_reg == BIT_CNT_ZERO
                    && addr_cnt_reg == ADDR_CNT_ZERO)
    else $error("Command state survived deselect.");

  a_input_sample_edge: assert property ( // [R7]
    @(posedge clk) disable iff (sys_rst)
    !rise |=> $stable(in_sh_reg))
    else $error("Serial input taken off a rising edge.");

  a_output_fall_only: assert property ( // [R5]
    @(posedge clk) disable iff (sys_rst)
    !fall |=> $stable(so_o))
    else $error("Serial output changed off a falling edge.");

  a_opcode_read: assert property ( // [R12]
    @(posedge clk) disable iff (sys_rst)
    byte_done && state_reg == ST_OPCODE && in_byte == OP_MEM_RD
    |=> state_reg == ST_ADDR && !is_write_reg)
    else $error("Read opcode not decoded.");

  a_bad_opcode_drop: assert property ( // [R14]
    @(posedge clk) disable iff (sys_rst)
    state_reg == ST_DISCARD && !pins_s.cs_n
    |=> state_reg == ST_DISCARD && !so_oe && !push && !rd_req)
    else $error("Input not discarded after invalid opcode.");

  a_protect_locks: assert property ( // [R9]
    @(posedge clk) disable iff (sys_rst)
    byte_done && state_reg == ST_WDATA && status_cmd_reg && wr_locked
    |=> $stable(status_reg) ##1 $stable(status_o))
    else $error("Protected status register was written.");

  a_status_msb_first: assert property ( // [R13]
    @(posedge clk) disable iff (sys_rst)
    byte_done && state_reg == ST_WDATA && status_cmd_reg && !wr_locked
    |=> status_reg == {$past(in_sh_reg), $past(pins_s.si)})
    else $error("Status byte not assembled first bit high.");

endmodule

// [bench/spmsp_master.sv]
`timescale 1ns/1ps
// Host controller on the far side of the pins; 64 ns serial clock.
module spmsp_master (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so
);
  localparam int HALF_NS = 32;
  logic mode3;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    mode3 = 1'b0;
  end
  // Clock idles at the mode level before select falls.
  // Starting on a falling clk edge keeps pin moves off the sampling edge.
  task automatic open_frame(input logic m3);
    @(negedge clk);
    mode3 = m3;
    sck = m3;
    #HALF_NS;
    cs_n = 1'b0;
    #HALF_NS;
  endtask
  task automatic close_frame();
    #HALF_NS;
    cs_n = 1'b1;
    // The data line is flipped once released, so no stale bit is trusted.
    si = ~si;
    #HALF_NS;
  endtask
  // Bits go out from bit 7 down and SO is taken at each rise.
  task automatic shift(input logic [7:0] tx, input int n, input int gap,
                       output logic [7:0] rx);
    rx = 8'h00;
    @(negedge clk);
    for (int i = 7; i > 7 - n; i--) begin
      sck = 1'b0;
      si = tx[i];
      #HALF_NS;
      sck = 1'b1;
      rx[i] = so;
      #HALF_NS;
      if (gap > 0 && i == 4) #gap;
    end
    if (!mode3) sck = 1'b0;
  endtask
endmodule

// [bench/spmsp_slave_test.sv]
`timescale 1ns/1ps
module spmsp_slave_test;
  import spmsp_pkg::*;
  logic       clk;
  logic       sys_rst;
  logic       wp_n;
  logic       rx_ready;
  logic [7:0] rd_byte;
  wire logic  cs_n;
  wire logic  sck;
  wire logic  si;
  wire logic  so_line;
  logic       so_o;
  logic       so_oe;
  logic       rx_valid;
  logic       rd_req;
  logic       standby;
  logic       overrun;
  logic       prot;
  logic [7:0] status_o;
  spmsp_rx_t  rx_data;
  spmsp_rx_t  rx_q[$];
  logic [7:0] rxb[6];
  int         num_errors = 0;
  int         check_count = 0;
  int         cycles = 0;

  // A shared data line only works if SO is released outside reads.
  assign so_line = so_oe ? so_o : 1'bz;
  spmsp_master m (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so_line));
  spmsp_slave dut (
    .clk(clk), .sys_rst(sys_rst), .cs_n_pin(cs_n), .sck_pin(sck),
    .si_pin(si), .wp_n_pin(wp_n), .so_o(so_o), .so_oe(so_oe),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rd_req(rd_req), .rd_byte(rd_byte), .standby(standby),
    .overrun(overrun), .status_protect_enable_bit(prot),
    .status_o(status_o)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rx_valid && rx_ready) rx_q.push_back(rx_data);
    if (sys_rst) rd_byte <= 8'hA4;
    else if (rd_req) rd_byte <= rd_byte + 8'h01;
    if (cycles == 60000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_clk(int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic send(logic m3, logic [47:0] w, int nb, int gap);
    logic [7:0] r;
    rx_q.delete();
    m.open_frame(m3);
    for (int k = 0; k < nb; k++) begin
      m.shift(w[47-8*k -: 8], 8, gap, r);
      rxb[k] = r;
    end
    wait_clk(8);
  endtask

  task automatic done();
    m.close_frame();
    wait_clk(8);
  endtask

  task automatic t_reset();
    check("standby", 16'(standby), 16'h0001);
    check("so_oe", 16'(so_oe), 16'h0000);
    check("status", 16'(status_o), 16'h0000);
  endtask

  task automatic t_status();
    send(1'b0, 48'h0180_0000_0000, 2, 0);
    done();
    check("status wr", 16'(status_o), 16'h0080);
    check("protect", 16'(prot), 16'h0001);
    send(1'b1, 48'h0500_0000_0000, 3, 0);
    done();
    check("opcode so", 16'(rxb[0]), 16'h00zz);
    check("stat rd", {rxb[1], rxb[2]}, 16'h8080);
  endtask

  task automatic t_protect();
    @(posedge clk) wp_n <= 1'b0;
    send(1'b0, 48'h0100_0000_0000, 2, 0);
    done();
    check("blocked", 16'(status_o), 16'h0080);
    @(posedge clk) wp_n <= 1'b1;
    send(1'b0, 48'h0100_0000_0000, 2, 0);
    done();
    check("open wr", 16'(status_o), 16'h0000);
    @(posedge clk) wp_n <= 1'b0;
    send(1'b0, 48'h010C_0000_0000, 2, 0);
    done();
    check("bit clear", 16'(status_o), 16'h000C);
    @(posedge clk) wp_n <= 1'b1;
  endtask

  task automatic t_write();
    @(posedge clk) rx_ready <= 1'b0;
    send(1'b0, 48'h0212_3456_9A00, 5, 0);
    check("selected", 16'(standby), 16'h0000);
    check("overrun", 16'(overrun), 16'h0001);
    done();
    check("ovr clear", 16'(overrun), 16'h0000);
    @(posedge clk) rx_ready <= 1'b1;
    wait_clk(6);
    check("kept", 16'(rx_q.size()), 16'h0002);
    check("kept0", 16'(rx_q[0][8:0]), 16'h0112);
    check("kept1", 16'(rx_q[1][8:0]), 16'h0134);
    send(1'b1, 48'h0212_3456_9ABC, 6, 2000);
    done();
    check("items", 16'(rx_q.size()), 16'h0005);
    check("a0", 16'(rx_q[0][8:0]), 16'h0112);
    check("a2", 16'(rx_q[2][8:0]), 16'h0156);
    check("d0", 16'(rx_q[3]), 16'h029A);
    check("d1", 16'(rx_q[4]), 16'h02BC);
  endtask

  task automatic t_read();
    send(1'b0, 48'h0300_0102_0000, 6, 0);
    done();
    check("addr so", 16'(rxb[3]), 16'h00zz);
    check("rd data", {rxb[4], rxb[5]}, 16'hA5A6);
    check("rd addr", 16'(rx_q.size()), 16'h0003);
  endtask

  task automatic t_invalid();
    send(1'b0, 48'hA705_0100_0000, 4, 0);
    done();
    check("inv so", {rxb[1], rxb[3]}, 16'hzzzz);
    check("inv rx", 16'(rx_q.size()), 16'h0000);
    check("inv st", 16'(status_o), 16'h000C);
  endtask

  task automatic t_abort_idle();
    logic [7:0] r;
    m.open_frame(1'b0);
    m.shift(8'h01, 8, 0, r);
    m.shift(8'hF0, 4, 0, r);
    done();
    check("partial", 16'(status_o), 16'h000C);
    m.shift(8'h01, 8, 0, r);
    m.shift(8'hF0, 8, 0, r);
    wait_clk(8);
    check("idle st", 16'(status_o), 16'h000C);
    check("idle oe", 16'(so_oe), 16'h0000);
    send(1'b0, 48'h0500_0000_0000, 2, 0);
    done();
    check("fresh", 16'(rxb[1]), 16'h000C);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    wp_n = 1'b1;
    rx_ready = 1'b1;
    wait_clk(20);
    sys_rst <= 1'b0;
    wait_clk(4);
    t_reset();
    t_status();
    t_protect();
    t_write();
    t_read();
    t_invalid();
    t_abort_idle();
    complete_run();
  end
endmodule
